// ### common/szc_pkg.sv
// Constants, field layouts and carrier types of the conversion sequencer.
// Assumes a single 125 MHz master clock and an AHB-Lite register bus.
package szc_pkg;

  // Decimation base count and filter orders in base periods.
  localparam int unsigned DEC_SHIFT   = 10;
  localparam int unsigned DEC_BASE    = 1 << DEC_SHIFT;
  localparam int unsigned DEC_W       = 20;
  localparam logic [2:0]  SINC4_TICKS = 3'h4;
  localparam logic [2:0]  THIRD_ORDER_SELECT_TICKS = 3'h3;
  localparam logic [2:0]  ONE_TICK    = 3'h1;

  // Register byte offsets.
  localparam logic [7:0]  MODE_OFF    = 8'h00;
  localparam logic [7:0]  CHAN_OFF    = 8'h04;
  localparam logic [7:0]  STAT_OFF    = 8'h08;
  localparam logic [7:0]  DATA_OFF    = 8'h0C;

  // Mode register field positions.
  localparam int unsigned RATE_LSB    = 0;
  localparam int unsigned RATE_W      = 10;
  localparam int unsigned ZL_BIT      = 11;
  localparam int unsigned CHOP_BIT    = 13;
  localparam int unsigned NOTCH_BIT   = 14;
  localparam int unsigned ORDER3_BIT  = 15;
  localparam int unsigned CHAN_W      = 4;

  // Status register field positions.
  localparam int unsigned ST_AVAIL    = 0;
  localparam int unsigned ST_POL      = 1;
  localparam int unsigned ST_HOLD     = 2;
  localparam int unsigned ST_SETTLED  = 3;
  localparam int unsigned ST_CNT_LSB  = 4;

  // Result word layout.
  localparam int unsigned DATA_W      = 24;
  localparam int unsigned RES_CH_LSB  = 28;

  // Reset values and legal range of the rate word.
  localparam logic [9:0]  RATE_RST    = 10'h060;
  localparam logic [9:0]  RATE_MIN    = 10'h001;
  localparam logic [3:0]  CHAN_RST    = 4'h0;

  // Result buffer shape.
  localparam int unsigned FIFO_WIDTH  = 32;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned FIFO_CNT_W  = 5;

  // AHB-Lite transfer type bit that marks an active transfer.
  localparam int unsigned HTRANS_ACT  = 1;
  localparam logic        HRESP_OKAY  = 1'b0;

  typedef enum logic [1:0] {
    SZC_RUN  = 2'b00,
    SZC_HOLD = 2'b01
  } szc_seq_e;

  typedef struct packed {
    logic        third_order_select;
    logic        line_notch_boost;
    logic        chop_en;
    logic        zero_latency;
    logic [9:0]  rate_word;
  } szc_mode_s;

  localparam szc_mode_s MODE_RST = '{1'b0, 1'b0, 1'b0, 1'b0, RATE_RST};

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } szc_ahb_req_s;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } szc_ahb_rsp_s;

  typedef struct packed {
    logic        mod_reset;
    logic        input_swap;
    logic        third_order_select;
    logic        line_notch_boost;
    logic [3:0]  channel;
  } szc_afe_ctl_s;

endpackage

// ### logic/szc_fifo.sv
// Result buffer: flip-flop storage with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module szc_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned CNT_W = 5
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Fill level.
  output logic [CNT_W-1:0]      level
);
  localparam int unsigned PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            cnt;
  } szc_fifo_state_s;

  szc_fifo_state_s s_q;
  szc_fifo_state_s s_d;
  logic            push;
  logic            pop;

  assign in_ready  = (s_q.cnt != CNT_W'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rd_ptr];
  assign level     = s_q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr_ptr] = in_data;
      s_d.wr_ptr          = s_q.wr_ptr + PTR_W'(1);
    end
    if (pop) begin
      s_d.rd_ptr = s_q.rd_ptr + PTR_W'(1);
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // szc_fifo

// ### logic/szc_seq_top.sv
// Conversion sequencer of a sigma-delta decimation filter with an AHB-Lite slave.
// Assumes the sinc core presents a settled word on flt_data at each conversion end.
//
// Contract
// - Mode bit 11 set selects zero-latency conversion; clear selects pipelined conversion.
// - Zero latency waits full settling: third_order_select conversion takes 3*1024*rate clocks.
// - Zero-latency period stays constant regardless of channel switches or sequences.
// - An unaligned input step yields one partial result, then settled results.
// - Rate word is ten bits, legal 1 to 1023, scaling every decimation period.
// - Chop flips input polarity every conversion and outputs consecutive averages.
// - Chop with sinc4 outputs one result every 4*1024*rate clocks.
// - Chop needs two output periods before a result reflects new input.
// - Chop channel change resets modulator and filter, then full settling.
// - Chop single channel keeps converting through steps at programmed rate.
// - Line notch bit adds 50/60 Hz rejection without changing output rate.
// - Chop sequence is the same with third_order_select; advised up to 320 Hz.
// - Filter select bit set chooses third_order_select, clear chooses sinc4.
// - Chop with third_order_select outputs one result every 3*1024*rate clocks.
//
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module szc_seq_top (
  // Clock and reset.
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  // Register bus.
  input  wire szc_pkg::szc_ahb_req_s ahb_req,
  output szc_pkg::szc_ahb_rsp_s   ahb_rsp,
  // Sinc core result.
  input  wire logic signed [23:0] flt_data,
  // Modulator, multiplexer and filter control.
  output szc_pkg::szc_afe_ctl_s   afe_ctl
);
  import szc_pkg::*;

  typedef struct packed {
    szc_mode_s          mode;
    logic [CHAN_W-1:0]  chan;
    logic [DEC_W-1:0]   dec_cnt;
    logic [2:0]         tick_cnt;
    logic [1:0]         conv_cnt;
    logic               pol;
    logic [24:0]        prev;
    logic [31:0]        res;
    szc_seq_e           seq;
    logic               mod_rst;
    logic               wr_pend;
    logic               rd_pend;
    logic [7:0]         addr;
    logic [31:0]        rdata;
  } szc_state_s;

  szc_state_s              s_q;
  szc_state_s              s_d;

  // Bus decode.
  logic                    take;
  logic                    pop;

  // Result buffer handshake and fill level.
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic [FIFO_WIDTH-1:0]   fifo_out_data;
  logic [FIFO_CNT_W-1:0]   fifo_level;

  // Decimation timing.
  logic                    restart;
  logic [9:0]              rate_eff;
  logic [DEC_W-1:0]        dec_limit;
  logic [2:0]              order_ticks;
  logic [2:0]              need_ticks;
  logic [2:0]              tick_next;

  // Chop arithmetic and settling status.
  logic [24:0]             samp;
  logic [24:0]             samp_signed;
  logic                    settled;

  // Packs the mode fields into their register word.
  function automatic logic [31:0] mode_word(input szc_mode_s m);
    logic [31:0] w;
    w                              = 32'h0000_0000;
    w[RATE_LSB +: RATE_W]          = m.rate_word;
    w[ZL_BIT]                      = m.zero_latency;
    w[CHOP_BIT]                    = m.chop_en;
    w[NOTCH_BIT]                   = m.line_notch_boost;
    w[ORDER3_BIT]                  = m.third_order_select;
    return w;
  endfunction

  // Builds a result word from channel and sample.
  function automatic logic [31:0] result_word(input logic [CHAN_W-1:0] ch,
                                              input logic [DATA_W-1:0] d);
    logic [31:0] w;
    w                              = 32'h0000_0000;
    w[RES_CH_LSB +: CHAN_W]        = ch;
    w[DATA_W-1:0]                  = d;
    return w;
  endfunction

  // Packs the status fields into their register word.
  function automatic logic [31:0] status_word(input logic                  avail,
                                              input logic                  pol,
                                              input logic                  hold,
                                              input logic                  done,
                                              input logic [FIFO_CNT_W-1:0] lvl);
    logic [31:0] w;
    w                              = 32'h0000_0000;
    w[ST_AVAIL]                    = avail;
    w[ST_POL]                      = pol;
    w[ST_HOLD]                     = hold;
    w[ST_SETTLED]                  = done;
    w[ST_CNT_LSB +: FIFO_CNT_W]    = lvl;
    return w;
  endfunction

  // Averages a held and a new chop sample; the halving rounds toward minus infinity.
  function automatic logic [DATA_W-1:0] chop_average(input logic [24:0] p,
                                                     input logic [24:0] c);
    logic [25:0] sum;
    sum = {p[24], p} + {c[24], c};
    return sum[24:1];
  endfunction

  // Bus address phase is taken when selected, active and the bus is ready.
  assign take = ahb_req.hsel && ahb_req.htrans[HTRANS_ACT] && ahb_req.hready;
  // A data register read drains one result from the buffer.
  assign pop  = s_q.rd_pend && (s_q.addr == DATA_OFF) && fifo_out_valid;

  // Rate word of zero is out of range and runs as the least legal value.
  assign rate_eff  = (s_q.mode.rate_word < RATE_MIN) ? RATE_MIN : s_q.mode.rate_word;
  // One decimation period is 1024 times the rate word in master clocks.
  assign dec_limit = {rate_eff, DEC_SHIFT'(0)} - DEC_W'(1);

  // Filter order sets the number of decimation periods for full settling.
  assign order_ticks = s_q.mode.third_order_select ? THIRD_ORDER_SELECT_TICKS : SINC4_TICKS;

  // Chop and zero latency settle fully for every conversion; pipelined mode only
  // after a restart. The notch bit never enters this count.
  always_comb begin
    if (s_q.mode.chop_en) begin
      need_ticks = order_ticks;
    end else if (s_q.mode.zero_latency) begin
      need_ticks = order_ticks;
    end else if (s_q.conv_cnt == 2'h0) begin
      need_ticks = order_ticks;
    end else begin
      need_ticks = ONE_TICK;
    end
  end

  assign tick_next   = s_q.tick_cnt + 3'h1;
  assign samp        = {flt_data[23], flt_data};
  // Input wired inverted is negated back before it is used.
  assign samp_signed = s_q.pol ? (25'h0 - samp) : samp;
  assign settled     = s_q.mode.chop_en ? (s_q.conv_cnt == 2'h2) : (s_q.conv_cnt != 2'h0);

  always_comb begin
    s_d         = s_q;
    s_d.mod_rst = 1'b0;
    restart     = 1'b0;

    // Write data phase.
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      case (s_q.addr)
        MODE_OFF: begin
          s_d.mode.rate_word          = ahb_req.hwdata[RATE_LSB +: RATE_W];
          s_d.mode.zero_latency       = ahb_req.hwdata[ZL_BIT];
          s_d.mode.chop_en            = ahb_req.hwdata[CHOP_BIT];
          s_d.mode.line_notch_boost   = ahb_req.hwdata[NOTCH_BIT];
          s_d.mode.third_order_select = ahb_req.hwdata[ORDER3_BIT];
          restart                     = 1'b1;
        end
        CHAN_OFF: begin
          s_d.chan = ahb_req.hwdata[CHAN_W-1:0];
          restart  = 1'b1;
        end
        STAT_OFF, DATA_OFF: begin
          restart = 1'b0;
        end
        default: begin
          restart = 1'b0;
        end
      endcase
    end

    // Read data phase: one wait cycle while the answer is registered.
    if (s_q.rd_pend) begin
      s_d.rd_pend = 1'b0;
      case (s_q.addr)
        MODE_OFF: s_d.rdata = mode_word(s_q.mode);
        CHAN_OFF: s_d.rdata = {28'h0, s_q.chan};
        STAT_OFF: s_d.rdata = status_word(fifo_out_valid, s_q.pol, (s_q.seq == SZC_HOLD),
                                          settled, fifo_level);
        DATA_OFF: s_d.rdata = fifo_out_valid ? fifo_out_data : 32'h0000_0000;
        default:  s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Address phase.
    if (take) begin
      s_d.wr_pend = ahb_req.hwrite;
      s_d.rd_pend = !ahb_req.hwrite;
      s_d.addr    = ahb_req.haddr[7:0];
    end

    // Conversion sequencing.
    if (restart) begin
      // New channel or mode resets modulator and filter and starts settling anew.
      s_d.mod_rst  = 1'b1;
      s_d.dec_cnt  = '0;
      s_d.tick_cnt = 3'h0;
      s_d.conv_cnt = 2'h0;
      s_d.pol      = 1'b0;
      s_d.seq      = SZC_RUN;
    end else begin
      case (s_q.seq)
        SZC_RUN: begin
          if (s_q.dec_cnt == dec_limit) begin
            s_d.dec_cnt = '0;
            if (tick_next >= need_ticks) begin
              // Conversion end. The period does not depend on the input, so an
              // unaligned step spoils only the conversion it falls in.
              s_d.tick_cnt = 3'h0;
              if (s_q.conv_cnt != 2'h2) begin
                s_d.conv_cnt = s_q.conv_cnt + 2'h1;
              end
              if (s_q.mode.chop_en) begin
                // Swap polarity each conversion; average once both are held.
                s_d.pol  = !s_q.pol;
                s_d.prev = samp_signed;
                if (s_q.conv_cnt != 2'h0) begin
                  s_d.res = result_word(s_q.chan, chop_average(s_q.prev, samp_signed));
                  s_d.seq = SZC_HOLD;
                end
              end else begin
                s_d.res = result_word(s_q.chan, samp_signed[DATA_W-1:0]);
                s_d.seq = SZC_HOLD;
              end
            end else begin
              s_d.tick_cnt = tick_next;
            end
          end else begin
            s_d.dec_cnt = s_q.dec_cnt + DEC_W'(1);
          end
        end
        SZC_HOLD: begin
          // Sequencing stalls while the result buffer is full.
          if (fifo_in_ready) begin
            s_d.seq = SZC_RUN;
          end
        end
        default: begin
          s_d.seq = SZC_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q.mode     <= MODE_RST;
      s_q.chan     <= CHAN_RST;
      s_q.dec_cnt  <= '0;
      s_q.tick_cnt <= 3'h0;
      s_q.conv_cnt <= 2'h0;
      s_q.pol      <= 1'b0;
      s_q.prev     <= '0;
      s_q.res      <= '0;
      s_q.seq      <= SZC_RUN;
      s_q.mod_rst  <= 1'b0;
      s_q.wr_pend  <= 1'b0;
      s_q.rd_pend  <= 1'b0;
      s_q.addr     <= 8'h00;
      s_q.rdata    <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  szc_fifo #(
    .WIDTH     (FIFO_WIDTH),
    .DEPTH     (FIFO_DEPTH),
    .CNT_W     (FIFO_CNT_W)
  ) u_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (s_q.seq == SZC_HOLD),
    .in_ready  (fifo_in_ready),
    .in_data   (s_q.res),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // Reads take one wait state while the answer is registered; every response is OKAY.
  assign ahb_rsp.hreadyout        = !s_q.rd_pend;
  assign ahb_rsp.hresp            = HRESP_OKAY;
  assign ahb_rsp.hrdata           = s_q.rdata;

  // Control bundle to the modulator, multiplexer and sinc core.
  assign afe_ctl.mod_reset          = s_q.mod_rst;
  assign afe_ctl.input_swap         = s_q.pol;
  assign afe_ctl.third_order_select = s_q.mode.third_order_select;
  assign afe_ctl.line_notch_boost   = s_q.mode.line_notch_boost;
  assign afe_ctl.channel            = s_q.chan;
endmodule // szc_seq_top

// ### bench/szc_seq_top_sva.sv
// Concurrent checks on the sequencer's ports.
// Assumes it is bound to szc_seq_top and that every write is a whole word.
`timescale 1ns/1ps
module szc_chk
  import szc_pkg::*;
(
  // Clock and reset.
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  // Bus and stream.
  input wire szc_pkg::szc_ahb_req_s ahb_req,
  input wire szc_pkg::szc_ahb_rsp_s ahb_rsp,
  input wire logic signed [23:0]    flt_data,
  input wire szc_pkg::szc_afe_ctl_s afe_ctl
);
  logic        hit;
  logic        wr_q;
  logic [7:0]  adr_q;
  logic [15:0] mode_q;
  int unsigned cnt_q;
  int unsigned per;

  assign hit = ahb_req.hsel & ahb_req.htrans[HTRANS_ACT] & ahb_req.hready;
  assign per = (mode_q[ORDER3_BIT] ? 3 : 4) * DEC_BASE
               * ((mode_q[9:0] == 10'h000) ? 1 : int'(mode_q[9:0]));

  // Mode shadow and cycles since the last polarity change or restart.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_q   <= 1'b0;
      adr_q  <= 8'h00;
      mode_q <= {6'h00, RATE_RST};
      cnt_q  <= 0;
    end else begin
      wr_q   <= hit & ahb_req.hwrite;
      adr_q  <= hit ? ahb_req.haddr[7:0] : adr_q;
      mode_q <= (wr_q && adr_q == MODE_OFF) ? ahb_req.hwdata[15:0] : mode_q;
      cnt_q  <= (afe_ctl.mod_reset || $changed(afe_ctl.input_swap)) ? 0 : cnt_q + 1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_RST_QUIET: assert property ($fell(sys_rst) |-> afe_ctl == '0)
    else $error("control bundle not clear after reset");
  AST_MOD_PULSE: assert property (wr_q && (adr_q == MODE_OFF || adr_q == CHAN_OFF)
    |=> afe_ctl.mod_reset ##1 !afe_ctl.mod_reset)
    else $error("restart pulse missing after mode or channel write");
  AST_ORDER_SEL: assert property (wr_q && adr_q == MODE_OFF
    |=> afe_ctl.third_order_select == $past(ahb_req.hwdata[ORDER3_BIT]))
    else $error("filter select does not follow mode write");
  AST_NOTCH: assert property (wr_q && adr_q == MODE_OFF
    |=> afe_ctl.line_notch_boost == $past(ahb_req.hwdata[NOTCH_BIT]))
    else $error("notch boost does not follow mode write");
  AST_CHAN: assert property (wr_q && adr_q == CHAN_OFF
    |=> afe_ctl.channel == $past(ahb_req.hwdata[3:0]))
    else $error("channel does not follow channel write");
  AST_RD_WAIT: assert property (hit && !ahb_req.hwrite
    |=> !ahb_rsp.hreadyout && ahb_rsp.hresp == HRESP_OKAY ##1 ahb_rsp.hreadyout)
    else $error("read wait state or response wrong");
  AST_SWAP_OFF: assert property (!mode_q[CHOP_BIT] && !afe_ctl.mod_reset
    |=> $stable(afe_ctl.input_swap) || afe_ctl.mod_reset)
    else $error("polarity changed with chop off");
  AST_SINC4_PER: assert property ($changed(afe_ctl.input_swap) && !afe_ctl.mod_reset
    && cnt_q > 3 && mode_q[CHOP_BIT] && !mode_q[ORDER3_BIT]
    |-> cnt_q + 4 >= per && cnt_q <= per + 2)
    else $error("fourth order chop period wrong");
  AST_THIRD_ORDER_SELECT_PER: assert property ($changed(afe_ctl.input_swap) && !afe_ctl.mod_reset
    && cnt_q > 3 && mode_q[CHOP_BIT] && mode_q[ORDER3_BIT]
    |-> cnt_q + 4 >= per && cnt_q <= per + 2)
    else $error("third order chop period wrong");
endmodule // szc_chk

// ### bench/szc_afe_model.sv
// Behavioural modulator, multiplexer and sinc core.
// Assumes the bench sets the analog level and the sequencer drives the control bundle.
`timescale 1ns/1ps
module szc_afe_model
  import szc_pkg::*;
(
  // Clock.
  input  wire logic                  mclk,
  // Control and level.
  input  wire szc_pkg::szc_afe_ctl_s afe_ctl,
  input  wire logic signed [23:0]    level,
  // Filter word.
  output logic signed [23:0]         flt_data
);
  // A swapped input pair presents the inverted level.
  always_ff @(posedge mclk) begin
    flt_data <= afe_ctl.input_swap ? -level : level;
  end
endmodule // szc_afe_model

// ### bench/szc_seq_top_tb.sv
// Self-checking bench: bus tasks, a queue of expected results and the partner model.
// Assumes the package, design, checker and partner files are compiled first.
`timescale 1ns/1ps
module szc_seq_top_tb;
  import szc_pkg::*;
  logic               mclk;
  logic               sys_rst;
  szc_ahb_req_s       m;
  szc_ahb_rsp_s       s;
  szc_afe_ctl_s       ctl;
  logic signed [23:0] flt;
  logic signed [23:0] lvl;
  logic [31:0]        rd;
  logic [3:0]         ch;
  int                 miscompares;
  int                 n_tests;
  int                 exp_q[$];

  szc_seq_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .ahb_req(m), .ahb_rsp(s),
                     .flt_data(flt), .afe_ctl(ctl));
  szc_afe_model i_afe (.mclk(mclk), .afe_ctl(ctl), .level(lvl), .flt_data(flt));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @* m.hready = s.hreadyout;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic rdy_wait();
    int n;
    n = 0;
    @(posedge mclk);
    while (s.hreadyout !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 50) begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    m.hsel   <= 1'b1;
    m.haddr  <= {24'h000000, a};
    m.htrans <= 2'h2;
    m.hwrite <= w;
    m.hsize  <= 3'h2;
    rdy_wait();
    m.hsel   <= 1'b0;
    m.htrans <= 2'h0;
    m.hwdata <= wd;
    rdy_wait();
    rd = s.hrdata;
  endtask

  task automatic drain();
    while (exp_q.size() > 0) begin
      bus(DATA_OFF, 1'b0, 32'h0);
      check("data", rd & 32'hF0FFFFFF, {ch, 4'h0, 24'(exp_q.pop_front())});
    end
  endtask

  initial begin
    int a;
    int b;
    sys_rst = 1'b1;
    m.hsel   = 1'b0;
    m.haddr  = 32'h0000_0000;
    m.htrans = 2'h0;
    m.hwrite = 1'b0;
    m.hsize  = 3'h0;
    m.hwdata = 32'h0000_0000;
    lvl = 24'sh000100;
    ch = 4'h0;
    miscompares = 0;
    n_tests = 0;
    a = $urandom(11931);
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(MODE_OFF, 1'b0, 32'h0);
    check("mode", rd, {22'h0, RATE_RST});
    bus(8'h20, 1'b0, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("Test reset done");
    for (int zl = 0; zl < 2; zl++) begin
      ch = 4'($urandom_range(0, 15));
      lvl <= 24'($urandom_range(1, 32'h3FFFFF));
      bus(CHAN_OFF, 1'b1, {28'h0, ch});
      bus(MODE_OFF, 1'b1, 32'h8001 | (zl << ZL_BIT));
      repeat (10752) @(posedge mclk);
      bus(STAT_OFF, 1'b0, 32'h0);
      check("level", (rd >> ST_CNT_LSB) & 32'h1F, zl ? 3 : 8);
      repeat (zl ? 3 : 8) exp_q.push_back(int'(lvl));
      drain();
      $display("Test latency %0d done", zl);
    end
    for (int o = 4; o > 2; o--) begin
      a = $urandom_range(1, 32'h3FFFFF);
      b = $urandom_range(1, 32'h3FFFFF);
      ch = 4'($urandom_range(0, 15));
      lvl <= 24'(a);
      bus(CHAN_OFF, 1'b1, {28'h0, ch});
      bus(MODE_OFF, 1'b1, (o == 3) ? 32'h0000E001 : 32'h00002001);
      repeat (o * 2560) @(posedge mclk);
      lvl <= 24'(b);
      repeat (o * 2048) @(posedge mclk);
      bus(STAT_OFF, 1'b0, 32'h0);
      check("chop level", (rd >> ST_CNT_LSB) & 32'h1F, 3);
      exp_q.push_back(a);
      exp_q.push_back((a + b) >>> 1);
      exp_q.push_back(b);
      drain();
      $display("Test chop order %0d done", o);
    end
    bus(MODE_OFF, 1'b1, 32'h00008001);
    repeat (20480) @(posedge mclk);
    bus(STAT_OFF, 1'b0, 32'h0);
    check("full", rd & 32'h1F4, 32'h104);
    repeat (17) exp_q.push_back(int'(lvl));
    drain();
    bus(DATA_OFF, 1'b0, 32'h0);
    check("empty", rd, 32'h0);
    $display("Test buffer done");
    stop_test();
  end
endmodule // szc_seq_top_tb

bind szc_seq_top szc_chk i_chk (.mclk(mclk), .sys_rst(sys_rst), .ahb_req(ahb_req),
                                .ahb_rsp(ahb_rsp), .flt_data(flt_data), .afe_ctl(afe_ctl));
